// ---- rtl/preset_count_map.vh ----
// Function
// - preset count only for fixed 512-byte blocks; standard-capacity cards refuse it
// - a card offering the 104 MHz mode must implement the preset count
// - support flag lives in card_configuration_register for the host to read
// - preset command answered with R1, never followed by busy on data
// - accepted only in transfer state; applies only to the next multi-block command
// - any other following command, status query included, discards the preset
// - on command crc error: no response, no count kept; host retries
// - several preset commands in a row: the latest count wins
// - a zero block count leaves transfer behaviour unchanged
// - count not checked; response still reports errors pending from earlier
// - count beyond user area: out-of-range error, stop at the boundary
// - aborted counted write may leave the rest of the range undefined
// - blocks beyond the preset count are not stored on a write
`ifndef PRESET_COUNT_MAP_VH
`define PRESET_COUNT_MAP_VH

// ----------------------------------------
// command indices
// ----------------------------------------
`define CMD_STOP 6'h0C
`define CMD_STATUS 6'h0D
`define CMD_RD_MULTI 6'h12
`define CMD_PRESET 6'h17
`define CMD_WR_MULTI 6'h19

// ----------------------------------------
// frame layout and fields
// ----------------------------------------
`define FRAME_LAST 6'h2F
`define CRC_SPAN 6'h28
`define CRC7_POLY 7'h09
`define CNT_MSB 31
`define CNT_LSB 0
`define STATE_TRAN 4'h4

// ----------------------------------------
// timing counts (link clock cycles) and sizes
// ----------------------------------------
`define NCR_CYC 2'h2
`define BLK_BYTES 10'h200
`define DATA_TAIL 5'h11
`define FIFO_W 8
`define FIFO_D 16

`endif

// ---- rtl/stream_fifo.v ----
`timescale 1ns/1ps
module stream_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire clk_sys,
    input wire rst_n,
    input wire [WIDTH-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0] wr_ptr;
    reg [AW:0] rd_ptr;
    wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire empty = (wr_ptr == rd_ptr);

    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr[AW-1:0]];

    always @(posedge clk_sys) begin
        if (in_valid && !full) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            wr_ptr <= {(AW+1){1'b0}};
            rd_ptr <= {(AW+1){1'b0}};
        end else begin
            if (in_valid && !full) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (out_ready && !empty) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule // stream_fifo

// ---- rtl/preset_count_ctrl.v ----
`timescale 1ns/1ps
`include "preset_count_map.vh"
module preset_count_ctrl #(
    parameter SUPPORT_PRESET = 1,
    parameter ULTRA_104 = 1,
    parameter FIFO_DEPTH = `FIFO_D,
    parameter FIFO_AW = 4
) (
    input wire clk_sys,
    input wire rst_n,
    input wire card_clk,
    input wire cmd_in,
    output reg cmd_out,
    output reg cmd_oe,
    input wire dat_in,
    output wire dat_out,
    output wire dat_oe,
    input wire high_capacity,
    input wire [3:0] card_state,
    input wire [31:0] card_status,
    input wire area_end,
    input wire blk_sent,
    output wire card_configuration_register,
    output reg cmd_valid,
    output reg [5:0] cmd_index,
    output reg [31:0] cmd_arg,
    output reg preset_armed,
    output reg [31:0] blocks_left,
    output reg xfer_active,
    output reg xfer_write,
    output reg xfer_end,
    output reg out_of_range,
    output reg write_abort,
    output reg overrun,
    output wire [7:0] wr_data,
    output wire wr_valid,
    input wire wr_ready
);
    localparam TX_IDLE = 2'h0;
    localparam TX_WAIT = 2'h1;
    localparam TX_SEND = 2'h2;
    localparam DAT_IDLE = 2'h0;
    localparam DAT_DATA = 2'h1;
    localparam DAT_TAIL = 2'h2;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function [6:0] crc7_step;
        input [6:0] c;
        input b;
        begin
            crc7_step = {c[5:0], 1'b0} ^ ((c[6] ^ b) ? `CRC7_POLY : 7'h00);
        end
    endfunction

    function [6:0] crc7_calc;
        input [39:0] d;
        integer i;
        reg [6:0] c;
        begin
            c = 7'h00;
            for (i = 39; i >= 0; i = i - 1) begin
                c = crc7_step(c, d[i]);
            end
            crc7_calc = c;
        end
    endfunction

    // ----------------------------------------
    // link synchronisers
    // ----------------------------------------
    reg [2:0] clk_s;
    reg [1:0] cmd_s;
    reg [1:0] dat_s;
    wire rise = clk_s[1] & ~clk_s[2];
    wire fall = ~clk_s[1] & clk_s[2];

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            clk_s <= 3'h0;
            cmd_s <= 2'h3;
            dat_s <= 2'h3;
        end else begin
            clk_s <= {clk_s[1:0], card_clk};
            cmd_s <= {cmd_s[0], cmd_in};
            dat_s <= {dat_s[0], dat_in};
        end
    end

    // ----------------------------------------
    // support flag
    // ----------------------------------------
    // standard capacity never offers it, whatever the parameters say
    assign card_configuration_register = (SUPPORT_PRESET != 0 || ULTRA_104 != 0) && high_capacity;

    // no busy after the preset answer; this block never drives data
    assign dat_out = 1'b1;
    assign dat_oe = 1'b0;

    // ----------------------------------------
    // command receiver
    // ----------------------------------------
    reg rx_busy;
    reg [5:0] rx_cnt;
    reg [47:0] rx_sh;
    reg [6:0] rx_crc;
    reg frame_done;
    reg [1:0] tx_state;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            rx_busy <= 1'b0;
            rx_cnt <= 6'h00;
            rx_sh <= 48'h0;
            rx_crc <= 7'h00;
            frame_done <= 1'b0;
        end else begin
            frame_done <= 1'b0;
            if (rise) begin
                if (!rx_busy) begin
                    if (!cmd_s[1] && tx_state == TX_IDLE) begin
                        rx_busy <= 1'b1;
                        rx_cnt <= 6'h01;
                        rx_sh <= 48'h0;
                        rx_crc <= crc7_step(7'h00, 1'b0);
                    end
                end else begin
                    rx_sh <= {rx_sh[46:0], cmd_s[1]};
                    if (rx_cnt < `CRC_SPAN) begin
                        rx_crc <= crc7_step(rx_crc, cmd_s[1]);
                    end
                    if (rx_cnt == `FRAME_LAST) begin
                        rx_busy <= 1'b0;
                        frame_done <= 1'b1;
                    end else begin
                        rx_cnt <= rx_cnt + 6'h01;
                    end
                end
            end
        end
    end

    wire [5:0] rx_idx = rx_sh[45:40];
    wire [31:0] rx_arg = rx_sh[39:8];
    wire frame_ok = rx_sh[46] & rx_sh[0] & (rx_sh[7:1] == rx_crc);
    wire in_tran = (card_state == `STATE_TRAN);

    // ----------------------------------------
    // decoder, counted transfer, data receiver
    // ----------------------------------------
    reg resp_req;
    reg [47:0] resp_word;
    reg [1:0] dat_state;
    reg [2:0] bit_cnt;
    reg [9:0] byte_cnt;
    reg [4:0] tail_cnt;
    reg [7:0] byte_sh;
    reg [7:0] hold_data;
    reg hold_valid;
    wire fifo_in_ready;
    wire last_blk = (blocks_left == 32'h1);
    wire [39:0] resp_body = {2'b00, `CMD_PRESET, card_status};

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            resp_req <= 1'b0;
            resp_word <= 48'h0;
            cmd_valid <= 1'b0;
            cmd_index <= 6'h00;
            cmd_arg <= 32'h0;
            preset_armed <= 1'b0;
            blocks_left <= 32'h0;
            xfer_active <= 1'b0;
            xfer_write <= 1'b0;
            xfer_end <= 1'b0;
            out_of_range <= 1'b0;
            write_abort <= 1'b0;
            overrun <= 1'b0;
            dat_state <= DAT_IDLE;
            bit_cnt <= 3'h0;
            byte_cnt <= 10'h000;
            tail_cnt <= 5'h00;
            byte_sh <= 8'h00;
            hold_data <= 8'h00;
            hold_valid <= 1'b0;
        end else begin
            resp_req <= 1'b0;
            cmd_valid <= 1'b0;
            xfer_end <= 1'b0;
            out_of_range <= 1'b0;
            write_abort <= 1'b0;
            overrun <= 1'b0;
            if (hold_valid && fifo_in_ready) begin
                hold_valid <= 1'b0;
            end
            if (frame_done) begin
                if (!frame_ok) begin
                    preset_armed <= 1'b0;
                end else begin
                    cmd_valid <= 1'b1;
                    cmd_index <= rx_idx;
                    cmd_arg <= rx_arg;
                    if (rx_idx == `CMD_STOP) begin
                        preset_armed <= 1'b0;
                        if (xfer_active) begin
                            // the host stops a counted run after an error
                            xfer_active <= 1'b0;
                            xfer_end <= 1'b1;
                            // the rest of the range may be left undefined; flag the abort
                            write_abort <= xfer_write;
                            dat_state <= DAT_IDLE;
                        end
                    end else if (rx_idx == `CMD_PRESET && card_configuration_register && in_tran) begin
                        // status carries errors left from earlier commands, count unchecked
                        resp_req <= 1'b1;
                        resp_word <= {resp_body, crc7_calc(resp_body), 1'b1};
                        if (rx_arg[`CNT_MSB:`CNT_LSB] == 32'h0) begin
                            preset_armed <= 1'b0;
                        end else begin
                            preset_armed <= 1'b1;
                            blocks_left <= rx_arg[`CNT_MSB:`CNT_LSB];
                        end
                    end else if ((rx_idx == `CMD_RD_MULTI || rx_idx == `CMD_WR_MULTI) && preset_armed && in_tran) begin
                        preset_armed <= 1'b0;
                        xfer_active <= 1'b1;
                        xfer_write <= (rx_idx == `CMD_WR_MULTI);
                        dat_state <= DAT_IDLE;
                    end else begin
                        preset_armed <= 1'b0;
                    end
                end
            end else if (xfer_active && area_end) begin
                xfer_active <= 1'b0;
                out_of_range <= 1'b1;
                xfer_end <= 1'b1;
                dat_state <= DAT_IDLE;
            end else if (xfer_active && !xfer_write && blk_sent) begin
                blocks_left <= blocks_left - 32'h1;
                if (last_blk) begin
                    xfer_active <= 1'b0;
                    xfer_end <= 1'b1;
                end
            end else if (xfer_active && xfer_write && rise) begin
                case (dat_state)
                    DAT_IDLE: begin
                        if (!dat_s[1]) begin
                            dat_state <= DAT_DATA;
                            bit_cnt <= 3'h0;
                            byte_cnt <= 10'h000;
                        end
                    end
                    DAT_DATA: begin
                        byte_sh <= {byte_sh[6:0], dat_s[1]};
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == 3'h7) begin
                            // a full hold means the drain stalled too long; byte lost
                            if (hold_valid && !fifo_in_ready) begin
                                overrun <= 1'b1;
                            end else begin
                                hold_data <= {byte_sh[6:0], dat_s[1]};
                                hold_valid <= 1'b1;
                            end
                            if (byte_cnt == `BLK_BYTES - 10'h001) begin
                                dat_state <= DAT_TAIL;
                                tail_cnt <= 5'h00;
                            end else begin
                                byte_cnt <= byte_cnt + 10'h001;
                            end
                        end
                    end
                    DAT_TAIL: begin
                        // crc16 and end bit are skipped, not checked
                        if (tail_cnt == `DATA_TAIL - 5'h01) begin
                            dat_state <= DAT_IDLE;
                            blocks_left <= blocks_left - 32'h1;
                            if (last_blk) begin
                                // later blocks find the receiver idle and are dropped
                                xfer_active <= 1'b0;
                                xfer_end <= 1'b1;
                            end
                        end else begin
                            tail_cnt <= tail_cnt + 5'h01;
                        end
                    end
                    default: begin
                        dat_state <= DAT_IDLE;
                    end
                endcase
            end
        end
    end

    // ----------------------------------------
    // response transmitter
    // ----------------------------------------
    reg [47:0] tx_sh;
    reg [5:0] tx_cnt;
    reg [1:0] ncr_cnt;

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            tx_state <= TX_IDLE;
            tx_sh <= 48'h0;
            tx_cnt <= 6'h00;
            ncr_cnt <= 2'h0;
            cmd_out <= 1'b1;
            cmd_oe <= 1'b0;
        end else begin
            case (tx_state)
                TX_IDLE: begin
                    // a crc failure never reaches here, so the line stays quiet
                    if (resp_req) begin
                        tx_sh <= resp_word;
                        ncr_cnt <= `NCR_CYC;
                        tx_state <= TX_WAIT;
                    end
                end
                TX_WAIT: begin
                    if (fall) begin
                        if (ncr_cnt == 2'h1) begin
                            tx_state <= TX_SEND;
                            tx_cnt <= 6'h00;
                        end else begin
                            ncr_cnt <= ncr_cnt - 2'h1;
                        end
                    end
                end
                TX_SEND: begin
                    if (fall) begin
                        if (tx_cnt == `FRAME_LAST + 6'h01) begin
                            cmd_oe <= 1'b0;
                            cmd_out <= 1'b1;
                            tx_state <= TX_IDLE;
                        end else begin
                            cmd_oe <= 1'b1;
                            cmd_out <= tx_sh[47];
                            tx_sh <= {tx_sh[46:0], 1'b1};
                            tx_cnt <= tx_cnt + 6'h01;
                        end
                    end
                end
                default: begin
                    tx_state <= TX_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // write data buffer
    // ----------------------------------------
    // hold register keeps one byte while the fifo is full; a further byte is dropped and flags overrun
    stream_fifo #(
        .WIDTH(`FIFO_W),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_data(hold_data),
        .in_valid(hold_valid),
        .in_ready(fifo_in_ready),
        .out_data(wr_data),
        .out_valid(wr_valid),
        .out_ready(wr_ready)
    );
endmodule // preset_count_ctrl

// ---- test/preset_count_monitor.sv ----
`timescale 1ns/1ps
`include "preset_count_map.vh"
module preset_count_monitor #(
    parameter SUPPORT_PRESET = 1,
    parameter ULTRA_104 = 1
) (
    input wire clk_sys,
    input wire rst_n,
    input wire cmd_out,
    input wire cmd_oe,
    input wire dat_oe,
    input wire high_capacity,
    input wire [3:0] card_state,
    input wire area_end,
    input wire blk_sent,
    input wire card_configuration_register,
    input wire cmd_valid,
    input wire [5:0] cmd_index,
    input wire [31:0] cmd_arg,
    input wire preset_armed,
    input wire [31:0] blocks_left,
    input wire xfer_active,
    input wire xfer_write,
    input wire xfer_end,
    input wire out_of_range,
    input wire write_abort,
    input wire wr_valid
);
    default clocking mon_cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // checks
    // ----------------------------------------
    never_busy_a: assert property (!dat_oe)
        else $error("data line driven");
    support_flag_a: assert property (
        card_configuration_register == ((SUPPORT_PRESET != 0 || ULTRA_104 != 0) && high_capacity))
        else $error("support flag wrong");
    preset_arm_a: assert property (
        cmd_valid && cmd_index == `CMD_PRESET && cmd_arg != 32'h00000000 && card_state == `STATE_TRAN
        && card_configuration_register |-> ##[0:1] (preset_armed && blocks_left == cmd_arg))
        else $error("preset count not held");
    zero_count_a: assert property (
        cmd_valid && cmd_index == `CMD_PRESET && cmd_arg == 32'h00000000 |-> ##[0:1] !preset_armed)
        else $error("zero count kept");
    other_drop_a: assert property (
        cmd_valid && cmd_index != `CMD_PRESET && cmd_index != `CMD_RD_MULTI && cmd_index != `CMD_WR_MULTI
        |-> ##[0:1] !preset_armed)
        else $error("count survived other command");
    count_start_a: assert property (
        cmd_valid && $past(preset_armed) && (cmd_index == `CMD_RD_MULTI || cmd_index == `CMD_WR_MULTI)
        |-> ##[0:1] (xfer_active && xfer_write == (cmd_index == `CMD_WR_MULTI)))
        else $error("counted transfer not started");
    count_end_a: assert property (
        xfer_active && !xfer_write && blk_sent && blocks_left == 32'h00000001 && !cmd_valid && !area_end
        |=> xfer_end && !xfer_active)
        else $error("no end after last block");
    area_stop_a: assert property (
        xfer_active && area_end && !cmd_valid |=> out_of_range && xfer_end && !xfer_active)
        else $error("no stop at area end");
    stop_abort_a: assert property (
        cmd_valid && cmd_index == `CMD_STOP && $past(xfer_active && xfer_write)
        |-> ##[0:1] (write_abort && xfer_end) ##1 !xfer_active)
        else $error("stop did not abort write");
    no_store_a: assert property ($rose(wr_valid) |-> $past(xfer_active && xfer_write))
        else $error("data stored outside counted write");
    resp_start_a: assert property ($rose(cmd_oe) |-> !cmd_out [*8])
        else $error("response start bits wrong");
endmodule // preset_count_monitor

bind preset_count_ctrl preset_count_monitor #(.SUPPORT_PRESET(SUPPORT_PRESET), .ULTRA_104(ULTRA_104))
    preset_count_monitor_i (.*);

// ---- test/host_link_model.sv ----
`timescale 1ns/1ps
module host_link_model (
    input wire clk_sys,
    input wire cmd_oe,
    input wire cmd_out,
    output reg card_clk,
    output reg host_oe,
    output reg host_bit,
    output reg host_dat
);
    integer resp_cnt;
    reg [47:0] resp;
    // link clock stands low outside frames; lines idle at pull-up level
    initial begin
        card_clk = 1'b0;
        host_oe = 1'b0;
        host_bit = 1'b1;
        host_dat = 1'b1;
        resp_cnt = 0;
        resp = 48'h000000000000;
    end
    // ----------------------------------------
    // frame helpers
    // ----------------------------------------
    function [6:0] crc7(input [39:0] d);
        integer i;
        reg fb;
        begin
            crc7 = 7'h00;
            for (i = 39; i >= 0; i = i - 1) begin
                fb = d[i] ^ crc7[6];
                crc7 = {crc7[5:0], 1'b0} ^ (fb ? 7'h09 : 7'h00);
            end
        end
    endfunction
    // sample just before the fall: the card's bit has stood five of the period's eight clocks by then
    task link_cycle(input c, input d);
        begin
            @(posedge clk_sys);
            if (cmd_oe === 1'b1) begin
                resp = {resp[46:0], cmd_out};
                resp_cnt = resp_cnt + 1;
            end
            card_clk <= 1'b0;
            host_bit <= c;
            host_dat <= d;
            repeat (4) @(posedge clk_sys);
            card_clk <= 1'b1;
            repeat (3) @(posedge clk_sys);
        end
    endtask
    task send_cmd(input [5:0] idx, input [31:0] arg, input bad);
        reg [47:0] f;
        integer i;
        begin
            f = {2'b01, idx, arg, crc7({2'b01, idx, arg}) ^ {6'h00, bad}, 1'b1};
            resp_cnt = 0;
            @(posedge clk_sys);
            host_oe <= 1'b1;
            for (i = 47; i >= 0; i = i - 1)
                link_cycle(f[i], 1'b1);
            host_oe <= 1'b0;
            repeat (60) link_cycle(1'b1, 1'b1);
            @(posedge clk_sys);
            card_clk <= 1'b0;
        end
    endtask
    task send_block(input integer nbytes);
        integer k;
        integer b;
        begin
            link_cycle(1'b1, 1'b0);
            for (k = 0; k < nbytes; k = k + 1) begin
                for (b = 7; b >= 0; b = b - 1)
                    link_cycle(1'b1, k[b]);
            end
            repeat (21) link_cycle(1'b1, 1'b1);
            @(posedge clk_sys);
            card_clk <= 1'b0;
        end
    endtask
endmodule // host_link_model

// ---- test/preset_block_count_control_bench.sv ----
`timescale 1ns/1ps
`include "preset_count_map.vh"
`define CHK(g, e) begin check_count = check_count + 1; if ((g) !== (e)) begin bad_count = bad_count + 1; \
    $display("ERROR %0t: got %0h want %0h", $time, (g), (e)); end end
module preset_block_count_control_bench;
    reg clk_sys = 1'b0;
    reg rst_n = 1'b0;
    reg high_capacity = 1'b1;
    reg [3:0] card_state = 4'h4;
    reg [31:0] card_status = 32'h00080000;
    reg area_end = 1'b0;
    reg blk_sent = 1'b0;
    reg wr_ready = 1'b0;
    wire card_clk, host_oe, host_bit, host_dat, cmd_out, cmd_oe, dat_out, dat_oe, card_configuration_register;
    wire cmd_valid, preset_armed, xfer_active, xfer_write, xfer_end, out_of_range, write_abort, overrun, wr_valid;
    wire [5:0] cmd_index;
    wire [31:0] cmd_arg, blocks_left;
    wire [7:0] wr_data;
    wire cmd_line = cmd_oe ? cmd_out : (host_oe ? host_bit : 1'b1);
    wire dat_line = dat_oe ? dat_out : host_dat;
    integer bad_count = 0, check_count = 0, n_end = 0, n_oor = 0, n_abort = 0, n_ovr = 0, n_pop = 0, exp_idx = 0;

    always #12.5 clk_sys = ~clk_sys;
    preset_count_ctrl preset_count_ctrl_i (.*, .cmd_in(cmd_line), .dat_in(dat_line));
    host_link_model host_link_model_i (.*);
    // ----------------------------------------
    // pulse counters and sink
    // ----------------------------------------
    always @(posedge clk_sys) begin
        if (xfer_end === 1'b1) n_end <= n_end + 1;
        if (out_of_range === 1'b1) n_oor <= n_oor + 1;
        if (write_abort === 1'b1) n_abort <= n_abort + 1;
        if (overrun === 1'b1) n_ovr <= n_ovr + 1;
        if (wr_valid === 1'b1 && wr_ready) begin
            `CHK(wr_data, exp_idx[7:0])
            n_pop <= n_pop + 1;
            exp_idx <= (exp_idx == 16) ? 18 : exp_idx + 1; // byte 17 lost to the stall
        end
    end
    task cmd(input [5:0] i, input [31:0] a);
        host_link_model_i.send_cmd(i, a, 1'b0);
    endtask
    task pulse(input a);
        begin
            @(posedge clk_sys);
            if (a) area_end <= 1'b1; else blk_sent <= 1'b1;
            @(posedge clk_sys);
            area_end <= 1'b0;
            blk_sent <= 1'b0;
            repeat (4) @(posedge clk_sys);
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_idle;
        begin
            `CHK({cmd_oe, dat_oe}, 2'b00)
            `CHK(card_configuration_register, 1'b1)
            @(posedge clk_sys) high_capacity <= 1'b0;
            repeat (2) @(posedge clk_sys);
            `CHK(card_configuration_register, 1'b0)
            @(posedge clk_sys) high_capacity <= 1'b1;
            $display("test idle done");
        end
    endtask
    task t_preset;
        reg [47:0] want;
        begin
            cmd(`CMD_PRESET, 32'h00000005);
            want = {2'b00, `CMD_PRESET, card_status, host_link_model_i.crc7({2'b00, `CMD_PRESET, card_status}), 1'b1};
            `CHK(host_link_model_i.resp_cnt, 48)
            `CHK(host_link_model_i.resp, want)
            `CHK(blocks_left, 32'h00000005)
            cmd(`CMD_PRESET, 32'h00000007);
            cmd(`CMD_PRESET, 32'h00000002);
            `CHK(blocks_left, 32'h00000002)
            cmd(`CMD_RD_MULTI, 32'h00000000);
            `CHK({preset_armed, xfer_active, xfer_write}, 3'b010)
            pulse(1'b0);
            `CHK(xfer_active, 1'b1)
            pulse(1'b0);
            `CHK(xfer_active, 1'b0)
            `CHK(n_end, 1)
            $display("test preset done");
        end
    endtask
    task t_cancel;
        integer c;
        begin
            for (c = 0; c < 5; c = c + 1) begin
                cmd(`CMD_PRESET, 32'h00000003);
                @(posedge clk_sys);
                card_state <= (c == 3) ? 4'h3 : 4'h4;
                high_capacity <= (c != 4);
                host_link_model_i.send_cmd((c == 0) ? `CMD_STATUS : `CMD_PRESET, (c == 1) ? 32'h00000000 : 32'h00000009,
                    c == 2);
                `CHK(preset_armed, 1'b0)
                if (c != 1) `CHK(host_link_model_i.resp_cnt, 0)
                @(posedge clk_sys);
                card_state <= 4'h4;
                high_capacity <= 1'b1;
                cmd(`CMD_RD_MULTI, 32'h00000000);
                `CHK(xfer_active, 1'b0)
            end
            $display("test cancel done");
        end
    endtask
    task t_range_abort;
        begin
            cmd(`CMD_PRESET, 32'hFFFFFFFF);
            `CHK(host_link_model_i.resp_cnt, 48)
            cmd(`CMD_RD_MULTI, 32'h00000000);
            pulse(1'b1);
            `CHK({xfer_active, n_oor[3:0], n_end[3:0]}, 9'h012)
            cmd(`CMD_PRESET, 32'h00000004);
            cmd(`CMD_WR_MULTI, 32'h00000000);
            `CHK(xfer_write, 1'b1)
            cmd(`CMD_STOP, 32'h00000000);
            `CHK({xfer_active, n_abort[3:0], n_end[3:0]}, 9'h013)
            $display("test range and abort done");
        end
    endtask
    task t_write;
        begin
            cmd(`CMD_PRESET, 32'h00000001);
            cmd(`CMD_WR_MULTI, 32'h00000000);
            `CHK({xfer_active, xfer_write}, 2'b11)
            // sink stalls until one byte past a full buffer, then drains
            fork
                host_link_model_i.send_block(512);
                begin
                    repeat (1195) @(posedge clk_sys);
                    wr_ready <= 1'b1;
                end
            join
            `CHK(n_ovr, 1)
            `CHK({n_pop, n_end}, {511, 4})
            `CHK({xfer_active, wr_valid}, 2'b00)
            host_link_model_i.send_block(32);
            `CHK({n_pop, n_ovr}, {511, 1})
            $display("test write done");
        end
    endtask
    task end_sim;
        begin
            $display("checks %0d mismatches %0d", check_count, bad_count);
            if (bad_count == 0 && check_count > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_idle;
        t_preset;
        t_cancel;
        t_range_abort;
        t_write;
        end_sim;
    end
    initial begin
        #(100000 * 25);
        bad_count = bad_count + 1;
        $display("ERROR %0t: watchdog expired", $time);
        end_sim;
    end
endmodule // preset_block_count_control_bench
